// ==== rtl/bus_zone_defs.svh ====
// Offsets, field positions, reset values and timing counts of the bus zone unit
`ifndef BUS_ZONE_DEFS_SVH
`define BUS_ZONE_DEFS_SVH
`define REG_BUS_UNIT_CONFIG 24'hfff900
`define REG_IO_ZONE_CONFIG 24'hfff902
`define REG_STATIC_ZONE0_CONFIG 24'hfff904
`define REG_STATIC_ZONE1_CONFIG 24'hfff906
`define REG_STATIC_ZONE2_CONFIG 24'hfff908
`define RST_BUS_UNIT_CONFIG 8'h07
`define RST_ZONE_CONFIG 16'h069f
`define BUS_UNIT_CONFIG_WRITE_KEEP 8'h06
`define FLD_EARLY_WRITE 0
`define FLD_WAIT_LSB 0
`define FLD_WAIT_MSB 2
`define FLD_HOLD_LSB 3
`define FLD_HOLD_MSB 4
`define FLD_FAST_READ 11
`define FLASH_PROG_START 24'h000000
`define FLASH_PROG_END 24'h03ffff
`define FLASH_DATA_START 24'h0d0000
`define FLASH_DATA_END 24'h0d1fff
`define ZONE1_START 24'h400000
`define ZONE1_END 24'h7fffff
`define ZONE2_START 24'h800000
`define ZONE2_END 24'hfeffff
`define IO_ZONE_START 24'hfffb00
`define IO_ZONE_END 24'hfffbff
`define EXT_SPACE_BYTES 25'h0c00000
`define CYC_NORMAL_READ 4'h2
`define CYC_FAST_READ 4'h1
`define CYC_LATE_WRITE 4'h2
`define CYC_EARLY_WRITE 4'h3
`define ENV_INTERNAL 3'h7
`define ENV_EXTERNAL 3'h3
`define ENV_ISP 3'h6
`define ENV_DEV 3'h0
`define ENV_DEV_INT 3'h1
`endif

// ==== rtl/bus_zone_pkg.sv ====
// Types of the bus zone unit
package bus_zone_pkg;
  typedef enum logic [2:0] {
    internal_program_mode, external_program_mode, development_mode,
    development_internal_mode, in_system_programming_mode
  } env_mode_type;
  typedef enum logic [2:0] {
    zoneNone, zoneFlash, zoneStatic1, zoneStatic2, zoneIo
  } zone_type;
endpackage : bus_zone_pkg

// ==== rtl/bus_zone_env_select.sv ====
// Operating environment capture from strap pins at reset release
`timescale 1ns/100ps
`include "bus_zone_defs.svh"
module bus_zone_env_select (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [2:0] environment_select_pins,
  input wire logic flashEmpty,
  output bus_zone_pkg::env_mode_type envMode,
  output logic envValid
);
  logic [2:0] pinSync1;
  logic [2:0] pinSync2;
  logic emptySync1;
  logic emptySync2;
  logic captured;

  always_ff @(posedge clk_sys) begin
    pinSync1 <= environment_select_pins;
    pinSync2 <= pinSync1;
    emptySync1 <= flashEmpty;
    emptySync2 <= emptySync1;
  end

  // Capture once at the first edge after reset release, keep thereafter
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      captured <= 1'b0;
      envValid <= 1'b0;
      envMode <= bus_zone_pkg::in_system_programming_mode;
    end else if (!captured) begin
      captured <= 1'b1;
      envValid <= 1'b1;
      case (pinSync2)
        `ENV_INTERNAL: envMode <= emptySync2 ? bus_zone_pkg::in_system_programming_mode
                                             : bus_zone_pkg::internal_program_mode;
        `ENV_EXTERNAL: envMode <= emptySync2 ? bus_zone_pkg::in_system_programming_mode
                                             : bus_zone_pkg::external_program_mode;
        `ENV_ISP: envMode <= bus_zone_pkg::in_system_programming_mode;
        `ENV_DEV: envMode <= bus_zone_pkg::development_mode;
        `ENV_DEV_INT: envMode <= bus_zone_pkg::development_internal_mode;
        default: envMode <= bus_zone_pkg::in_system_programming_mode;
      endcase
    end
  end
endmodule : bus_zone_env_select

// ==== rtl/bus_zone_interface_unit.sv ====
// Bus zone unit: address decode, cycle timing and configuration registers
`timescale 1ns/100ps
`include "bus_zone_defs.svh"
// How it works
// - Decode 16 MB space, route each access
// - Program flash range is static zone 0
// - Data flash range also static zone 0
// - Zone 1 range goes external
// - Zone 2 range goes external
// - Environment from straps at reset plus empty
// - Pins 111: internal, or IN_SYSTEM_PROGRAMMING_MODE if empty
// - Pins 011: external, or IN_SYSTEM_PROGRAMMING_MODE if empty
// - Pins 110: always IN_SYSTEM_PROGRAMMING_MODE
// - Pins 000 development, 001 development internal
// - Development maps zone 0 external
// - Development internal keeps zone 0 onchip
// - External space at most 12 MB outside development mode
// - Serve flash and IO zone with settings
// - Cycle type from direction, target, config
// - Normal read two clocks, fast one
// - Normal reads after reset
// - Late write two clocks, early three
// - Early write default, software selects late
// - Wait cycles follow address phase
// - Hold cycles keep data at end
// - Three bit wait adds zero to seven
// - Two bit hold adds zero to three
module bus_zone_interface_unit (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [2:0] environment_select_pins,
  input wire logic flashEmpty,
  input wire logic [23:0] regAddr,
  input wire logic [15:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regReadData,
  input wire logic cpuReq,
  input wire logic cpuWrite,
  input wire logic [23:0] cpuAddr,
  input wire logic [15:0] cpuWriteData,
  output logic cpuReady,
  output logic [15:0] cpuReadData,
  output logic busy,
  output logic [23:0] memAddr,
  output logic [15:0] memWriteData,
  input wire logic [15:0] memReadData,
  output logic flashSelect,
  output logic extSelect,
  output logic ioSelect,
  output logic memReadStrobe,
  output logic memWriteStrobe,
  output logic [2:0] envMode,
  output logic envValid
);
  typedef enum logic [1:0] {stIdle, stAccess, stWait, stHold} bus_state_type;

  bus_zone_pkg::env_mode_type mode;
  bus_state_type state;
  logic [7:0] bus_unit_config;
  logic [15:0] io_zone_config;
  logic [15:0] static_zone0_config;
  logic [15:0] static_zone1_config;
  logic [15:0] static_zone2_config;
  logic [3:0] baseCount;
  logic [2:0] waitCount;
  logic [1:0] holdCount;
  logic curWrite;
  bus_zone_pkg::zone_type curZone;
  bus_zone_pkg::zone_type reqZone;
  logic [15:0] reqCfg;
  logic reqFast;
  logic [3:0] reqBase;
  logic [2:0] reqWait;
  logic [1:0] reqHold;
  logic accept;
  logic [4:0] regSel;

  bus_zone_env_select envSelect (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .environment_select_pins(environment_select_pins),
    .flashEmpty(flashEmpty),
    .envMode(mode),
    .envValid(envValid)
  );
  assign envMode = mode;

  function automatic logic inRange(input logic [23:0] a, input logic [23:0] lo, input logic [23:0] hi);
    inRange = (a >= lo) && (a <= hi);
  endfunction : inRange

  // Zone decode; unlisted regions give zoneNone
  function automatic bus_zone_pkg::zone_type decodeZone(input logic [23:0] a);
    if (inRange(a, `FLASH_PROG_START, `FLASH_PROG_END) || inRange(a, `FLASH_DATA_START, `FLASH_DATA_END)) begin
      decodeZone = bus_zone_pkg::zoneFlash;
    end else if (inRange(a, `ZONE1_START, `ZONE1_END)) begin
      decodeZone = bus_zone_pkg::zoneStatic1;
    end else if (inRange(a, `ZONE2_START, `ZONE2_END)) begin
      decodeZone = bus_zone_pkg::zoneStatic2;
    end else if (inRange(a, `IO_ZONE_START, `IO_ZONE_END)) begin
      decodeZone = bus_zone_pkg::zoneIo;
    end else begin
      decodeZone = bus_zone_pkg::zoneNone;
    end
  endfunction : decodeZone

  function automatic logic zoneIsExternal(input bus_zone_pkg::zone_type z, input bus_zone_pkg::env_mode_type m);
    zoneIsExternal = (z == bus_zone_pkg::zoneStatic1) || (z == bus_zone_pkg::zoneStatic2)
      || ((z == bus_zone_pkg::zoneFlash) && (m == bus_zone_pkg::development_mode));
  endfunction : zoneIsExternal

  always_comb begin
    reqZone = decodeZone(cpuAddr);
    case (reqZone)
      bus_zone_pkg::zoneFlash: reqCfg = static_zone0_config;
      bus_zone_pkg::zoneStatic1: reqCfg = static_zone1_config;
      bus_zone_pkg::zoneStatic2: reqCfg = static_zone2_config;
      bus_zone_pkg::zoneIo: reqCfg = io_zone_config;
      default: reqCfg = 16'h0000;
    endcase
    reqFast = reqCfg[`FLD_FAST_READ] && (reqZone == bus_zone_pkg::zoneFlash);
    if (cpuWrite) begin
      reqBase = bus_unit_config[`FLD_EARLY_WRITE] ? `CYC_EARLY_WRITE : `CYC_LATE_WRITE;
    end else begin
      reqBase = reqFast ? `CYC_FAST_READ : `CYC_NORMAL_READ;
    end
    // Fast read ignores wait and hold; non-zone ignores both
    if (reqZone == bus_zone_pkg::zoneNone || (!cpuWrite && reqFast)) begin
      reqWait = 3'h0;
      reqHold = 2'h0;
    end else begin
      reqWait = reqCfg[`FLD_WAIT_MSB:`FLD_WAIT_LSB];
      reqHold = reqCfg[`FLD_HOLD_MSB:`FLD_HOLD_LSB];
    end
  end

  // Register offset decode, shared by the write and read paths
  function automatic logic [4:0] regSelectOf(input logic [23:0] a);
    case (a)
      `REG_BUS_UNIT_CONFIG: regSelectOf = 5'h01;
      `REG_IO_ZONE_CONFIG: regSelectOf = 5'h02;
      `REG_STATIC_ZONE0_CONFIG: regSelectOf = 5'h04;
      `REG_STATIC_ZONE1_CONFIG: regSelectOf = 5'h08;
      `REG_STATIC_ZONE2_CONFIG: regSelectOf = 5'h10;
      default: regSelectOf = 5'h00;
    endcase
  endfunction : regSelectOf

  assign regSel = regSelectOf(regAddr);

  // Configuration register writes; unmapped offsets ignored
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      bus_unit_config <= `RST_BUS_UNIT_CONFIG;
      io_zone_config <= `RST_ZONE_CONFIG;
      static_zone0_config <= `RST_ZONE_CONFIG;
      static_zone1_config <= `RST_ZONE_CONFIG;
      static_zone2_config <= `RST_ZONE_CONFIG;
    end else if (regWrite) begin
      if (regSel[0]) begin
        bus_unit_config <= regWriteData[7:0] | `BUS_UNIT_CONFIG_WRITE_KEEP;
      end
      if (regSel[1]) begin
        io_zone_config <= regWriteData;
      end
      if (regSel[2]) begin
        static_zone0_config <= regWriteData;
      end
      if (regSel[3]) begin
        static_zone1_config <= regWriteData;
      end
      if (regSel[4]) begin
        static_zone2_config <= regWriteData;
      end
    end
  end

  // Register read, data one cycle later; unmapped reads zero
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      regReadData <= 16'h0000;
    end else if (regRead && regSel[0]) begin
      regReadData <= {8'h00, bus_unit_config};
    end else if (regRead && regSel[1]) begin
      regReadData <= io_zone_config;
    end else if (regRead && regSel[2]) begin
      regReadData <= static_zone0_config;
    end else if (regRead && regSel[3]) begin
      regReadData <= static_zone1_config;
    end else if (regRead && regSel[4]) begin
      regReadData <= static_zone2_config;
    end else begin
      regReadData <= 16'h0000;
    end
  end

  // Requests are taken only between cycles and once the environment is known
  assign accept = (state == stIdle) && cpuReq && envValid;

  // Bus cycle sequencer: waits, access, then hold
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state <= stIdle;
    end else begin
      case (state)
        stIdle: begin
          if (accept) begin
            state <= (reqWait != 3'h0) ? stWait : stAccess;
          end
        end
        stWait: begin
          if (waitCount == 3'h1) begin
            state <= stAccess;
          end
        end
        stAccess: begin
          if (baseCount == 4'h1) begin
            state <= (holdCount != 2'h0) ? stHold : stIdle;
          end
        end
        stHold: begin
          if (holdCount == 2'h1) begin
            state <= stIdle;
          end
        end
        default: begin
          state <= stIdle;
        end
      endcase
    end
  end

  // Wait clocks right after the address is placed
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      waitCount <= 3'h0;
    end else if (accept) begin
      waitCount <= reqWait;
    end else if (state == stWait) begin
      waitCount <= waitCount - 3'h1;
    end
  end

  // Basic clocks of the access phase
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      baseCount <= 4'h0;
    end else if (accept) begin
      baseCount <= reqBase;
    end else if (state == stAccess) begin
      baseCount <= baseCount - 4'h1;
    end
  end

  // Hold clocks at the end of the cycle
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      holdCount <= 2'h0;
    end else if (accept) begin
      holdCount <= reqHold;
    end else if (state == stHold) begin
      holdCount <= holdCount - 2'h1;
    end
  end

  // Direction and zone of the running cycle
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      curWrite <= 1'b0;
      curZone <= bus_zone_pkg::zoneNone;
    end else if (accept) begin
      curWrite <= cpuWrite;
      curZone <= reqZone;
    end
  end

  // Address and write data stay put for the whole cycle, hold clocks included
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      memAddr <= 24'h000000;
      memWriteData <= 16'h0000;
    end else if (accept) begin
      memAddr <= cpuAddr;
      memWriteData <= cpuWriteData;
    end
  end

  // Read data captured in last access clock
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cpuReadData <= 16'h0000;
    end else if (state == stAccess && baseCount == 4'h1 && !curWrite) begin
      cpuReadData <= memReadData;
    end
  end

  logic lastCycle;
  assign lastCycle = (state == stHold && holdCount == 2'h1)
                  || (state == stAccess && baseCount == 4'h1 && holdCount == 2'h0);
  assign cpuReady = lastCycle;
  assign busy = (state != stIdle);
  assign memReadStrobe = (state == stAccess) && !curWrite;
  assign memWriteStrobe = (state == stAccess) && curWrite;
  assign flashSelect = busy && (curZone == bus_zone_pkg::zoneFlash) && !zoneIsExternal(curZone, mode);
  assign extSelect = busy && zoneIsExternal(curZone, mode);
  assign ioSelect = busy && (curZone == bus_zone_pkg::zoneIo);
endmodule : bus_zone_interface_unit

// ==== testbench/bus_zone_props.sv ====
// Port checker of the bus zone unit
`timescale 1ns/100ps
module bus_zone_props (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic regRead,
  input wire logic [15:0] regReadData,
  input wire logic cpuReq,
  input wire logic cpuWrite,
  input wire logic cpuReady,
  input wire logic busy,
  input wire logic [23:0] memAddr,
  input wire logic [15:0] memWriteData,
  input wire logic flashSelect,
  input wire logic extSelect,
  input wire logic ioSelect,
  input wire logic memReadStrobe,
  input wire logic memWriteStrobe,
  input wire logic [2:0] envMode,
  input wire logic envValid
);
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  readGap_a: assert property (!regRead |=> regReadData == 16'h0000)
    else $error("read data outside read slot");
  busyCause_a: assert property ($rose(busy) |-> $past(cpuReq) && $past(envValid))
    else $error("cycle without request");
  readyEnd_a: assert property (cpuReady |-> busy ##1 !busy)
    else $error("ready not at cycle end");
  plainRead_a: assert property ($rose(busy) && !cpuWrite && !(flashSelect || extSelect || ioSelect)
    |-> !cpuReady ##1 cpuReady)
    else $error("unzoned read not two clocks");
  ioRange_a: assert property (ioSelect |-> busy && memAddr[23:8] == 16'hfffb)
    else $error("io select outside io zone");
  flashRange_a: assert property (flashSelect |-> envMode != 3'h2 && (memAddr <= 24'h03ffff
    || memAddr[23:13] == 11'h068))
    else $error("flash select misplaced");
  extRange_a: assert property (extSelect && envMode != 3'h2 |-> memAddr >= 24'h400000
    && memAddr <= 24'hfeffff)
    else $error("external select misplaced");
  strobeDir_a: assert property (memWriteStrobe |-> busy && cpuWrite && !memReadStrobe)
    else $error("write strobe wrong");
  envHold_a: assert property (envValid |=> envValid && $stable(envMode))
    else $error("environment changed");
  readStrobe_a: assert property (memReadStrobe |-> busy && !cpuWrite && !memWriteStrobe)
    else $error("read strobe wrong");
  addrHold_a: assert property (busy && $past(busy) |-> $stable(memAddr) && $stable(memWriteData))
    else $error("address or data moved within cycle");
endmodule : bus_zone_props
bind bus_zone_interface_unit bus_zone_props props (.*);

// ==== testbench/zone_memory_model.sv ====
// Memory model on the far side of the bus zone unit
`timescale 1ns/100ps
module zone_memory_model (
  input wire logic clk_sys,
  input wire logic [23:0] memAddr,
  input wire logic memReadStrobe,
  output logic [15:0] memReadData
);
  logic [15:0] churn = 16'h0000;
  // Released bus shows a pattern that changes every cycle
  always @(posedge clk_sys) begin
    churn <= churn + 16'h3c5b;
  end
  assign memReadData = memReadStrobe ? ~memAddr[15:0] : churn;
endmodule : zone_memory_model

// ==== testbench/testbench.sv ====
// Register and access cycle tests of the bus zone unit
`timescale 1ns/100ps
module testbench;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] environment_select_pins = 3'h7;
  logic flashEmpty = 1'b0;
  logic [23:0] regAddr = 24'h000000;
  logic [15:0] regWriteData = 16'h0000;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic cpuReq = 1'b0;
  logic cpuWrite = 1'b0;
  logic [23:0] cpuAddr = 24'h000000;
  logic [15:0] cpuWriteData = 16'h0000;
  logic cpuReady, busy, flashSelect, extSelect, ioSelect, memReadStrobe, memWriteStrobe, envValid;
  logic [15:0] regReadData, cpuReadData, memWriteData, memReadData;
  logic [23:0] memAddr;
  logic [2:0] envMode;
  logic [3:0] envIn [7] = '{4'he, 4'h6, 4'hf, 4'h7, 4'h1, 4'h3, 4'hc};
  logic [2:0] envExp [7] = '{3'h0, 3'h1, 3'h4, 3'h4, 3'h2, 3'h3, 3'h4};
  int err_total = 0;
  int checks = 0;
  bus_zone_interface_unit dut (.*);
  zone_memory_model partner (.*);
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  task check(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task stop_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  task regWr(input logic [23:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask : regWr
  task regRd(input logic [23:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 check(regReadData, exp);
  endtask : regRd
  // Optional config write, then one access; length counted in busy cycles
  task op(input logic [23:0] ra, input logic [15:0] rd, input logic w, input logic [23:0] a,
    input int len, input logic [2:0] sel);
    int n;
    logic [2:0] seen;
    logic [15:0] wdat;
    logic [15:0] rexp;
    n = 0;
    seen = 3'h0;
    wdat = 16'h0000;
    rexp = ~a[15:0];
    if (ra != 24'h000000) regWr(ra, rd);
    @(posedge clk_sys);
    cpuReq <= 1'b1;
    cpuWrite <= w;
    cpuAddr <= a;
    cpuWriteData <= a[15:0] ^ 16'h0f0f;
    while (cpuReady !== 1'b1 && n < 40) begin
      @(negedge clk_sys);
      if (busy === 1'b1) n++;
      if (n == 1) seen = {flashSelect, extSelect, ioSelect};
      if (memWriteStrobe === 1'b1) wdat = memWriteData;
    end
    @(posedge clk_sys);
    cpuReq <= 1'b0;
    #1 check(24'(n), 24'(len));
    check(24'(seen), 24'(sel));
    if (w) check(24'(wdat), 24'(a[15:0] ^ 16'h0f0f));
    if (!w) check(24'(cpuReadData), 24'(rexp));
  endtask : op
  initial begin
    #200000 err_total++;
    stop_test();
  end
  initial begin
    for (int i = 0; i < 7; i++) begin
      @(posedge clk_sys);
      reset_n <= 1'b0;
      environment_select_pins <= envIn[i][3:1];
      flashEmpty <= envIn[i][0];
      repeat (10) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (2) @(negedge clk_sys);
      check(24'(envValid), 24'h000001);
      check(24'(envMode), 24'(envExp[i]));
      op(24'h000000, 16'h0000, 1'b0, 24'h000010, 12, envExp[i] == 3'h2 ? 3'h2 : 3'h4);
    end
    $display("test environment done");
    regRd(24'hfff900, 16'h0007);
    for (int i = 1; i < 5; i++) regRd(24'hfff900 + 24'(2 * i), 16'h069f);
    regRd(24'hfff90a, 16'h0000);
    regWr(24'hfff900, 16'h0000);
    regRd(24'hfff900, 16'h0006);
    regWr(24'hfff900, 16'h0007);
    $display("test registers done");
    op(24'h000000, 16'h0000, 1'b1, 24'h000020, 13, 3'h4);
    op(24'hfff900, 16'h0006, 1'b1, 24'h000020, 12, 3'h4);
    op(24'hfff904, 16'h0000, 1'b0, 24'h000030, 2, 3'h4);
    op(24'h000000, 16'h0000, 1'b1, 24'h000030, 2, 3'h4);
    op(24'hfff904, 16'h081f, 1'b0, 24'h0d0100, 1, 3'h4);
    op(24'h000000, 16'h0000, 1'b1, 24'h0d0100, 12, 3'h4);
    op(24'hfff906, 16'h0005, 1'b0, 24'h400000, 7, 3'h2);
    op(24'hfff908, 16'h0010, 1'b0, 24'h8abcde, 4, 3'h2);
    op(24'hfff902, 16'h0001, 1'b1, 24'hfffb10, 3, 3'h1);
    op(24'h000000, 16'h0000, 1'b0, 24'h0e0000, 2, 3'h0);
    op(24'h000000, 16'h0000, 1'b1, 24'hfff200, 2, 3'h0);
    $display("test cycles done");
    stop_test();
  end
endmodule : testbench
